// *** ecs_map.vh ***
// constants for the external chip select decoder
// assumes an 8-bit control byte and 8-bit bounds per select
`ifndef ECS_MAP_VH
`define ECS_MAP_VH
`define ECS_NUM_SEL 4
`define ECS_CTL_IO_BIT 4
`define ECS_CTL_EN_BIT 3
`define ECS_CTL_WAIT_HI 7
`define ECS_CTL_WAIT_LO 5
`define ECS_CTL_RESET 8'h00
`define ECS_LBR_RESET 8'h00
`define ECS_UBR0_RESET 8'hff
`define ECS_UBRX_RESET 8'h00
`define ECS_MEM_HI 23
`define ECS_MEM_LO 16
`define ECS_IO_HI 15
`define ECS_IO_LO 8
`define ECS_PERIPH_LO 16'h0080
`define ECS_PERIPH_HI 16'h00ff
`define ECS_WAIT_MAX 3'h7
`endif

// *** ecs_decoder.v ***
// external chip select decoder: four active-low selects, strobes, wait states
// assumes the core gives a registered address, access request and direction
// Behaviour
// RULE1 - four independent active-low chip select outputs numbered 0 to 3
// RULE2 - control bit 4 picks memory (0) or I/O (1) space, never both
// RULE3 - after reset every select is configured for memory space
// RULE4 - a select asserts only when control bit 3 enable is one
// RULE5 - each memory select uses control, lower bound and upper bound registers
// RULE6 - memory hit when address bits 23:16 lie within lower and upper bound
// RULE7 - memory regions have 64 KB granularity, comparing top address byte only
// RULE8 - equal bounds cover exactly one 64 KB page
// RULE9 - lowest-numbered matching enabled select wins, others suppressed
// RULE10 - memory selects assert only during memory accesses, never I/O
// RULE11 - memory win drives select, memory request and read or write low
// RULE12 - an I/O select decodes exactly one 256-byte I/O section
// RULE13 - each select supports programmable wait states up to seven
// RULE14 - reset bounds: select 0 is 00h..FFh, others 00h..00h
// RULE15 - wait count is control bits 7:5, idling core that many cycles; code loads it only for a hit after a cycle with no access
// RULE16 - I/O match when address bits 15:8 equal lower bound
// RULE17 - no I/O select for 0080h..00FFh; I/O match drives I/O request
// RULE18 - select lines stay high unless all their conditions hold
// RULE19 - external device answers only with its select and request low
`include "ecs_map.vh"
module ecs_decoder #(
	parameter NSEL = `ECS_NUM_SEL
) (
	input wire clock_in,
	input wire rst_n_in,
	input wire [23:0] addr_in,
	input wire mem_access_in,
	input wire io_access_in,
	input wire write_in,
	input wire [7:0] select_control_reg_0_in,
	input wire [7:0] select_control_reg_1_in,
	input wire [7:0] select_control_reg_2_in,
	input wire [7:0] select_control_reg_3_in,
	input wire [7:0] lower_bound_reg_0_in,
	input wire [7:0] lower_bound_reg_1_in,
	input wire [7:0] lower_bound_reg_2_in,
	input wire [7:0] lower_bound_reg_3_in,
	input wire [7:0] upper_bound_reg_0_in,
	input wire [7:0] upper_bound_reg_1_in,
	input wire [7:0] upper_bound_reg_2_in,
	input wire [7:0] upper_bound_reg_3_in,
	input wire cfg_load_in,
	output reg select_line_0_n_out,
	output reg select_line_1_n_out,
	output reg select_line_2_n_out,
	output reg select_line_3_n_out,
	output reg memory_request_strobe_n_out,
	output reg io_request_strobe_n_out,
	output reg read_strobe_n_out,
	output reg write_strobe_n_out,
	output reg core_wait_out
);
	// configuration is latched on cfg_load_in so reset values are well defined
	wire [3:0] hit;
	wire [3:0] slot_io;
	wire [11:0] slot_wait;
	reg [2:0] wait_cnt_q;
	reg [2:0] wait_cnt_d;
	reg [3:0] win;
	reg any_win;
	reg win_io;
	reg [2:0] win_wait;
	reg prev_access_q;
	integer j;
	wire [7:0] mem_byte = addr_in[`ECS_MEM_HI:`ECS_MEM_LO];
	wire [7:0] io_byte = addr_in[`ECS_IO_HI:`ECS_IO_LO];
	wire [15:0] io_addr = addr_in[15:0];
	wire access = mem_access_in | io_access_in;
	// RULE17 on-chip peripheral window
	wire periph = (io_addr >= `ECS_PERIPH_LO) && (io_addr <= `ECS_PERIPH_HI);

	// select 0 bounds span all memory after reset, the others page 00h; all start disabled
	ecs_sel_slot #(
		.UBR_RESET(`ECS_UBR0_RESET)
	) slot0_u (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.cfg_load_in(cfg_load_in),
		.ctl_in(select_control_reg_0_in),
		.lbr_in(lower_bound_reg_0_in),
		.ubr_in(upper_bound_reg_0_in),
		.mem_byte_in(mem_byte),
		.io_byte_in(io_byte),
		.mem_access_in(mem_access_in),
		.io_access_in(io_access_in),
		.periph_in(periph),
		.hit_out(hit[0]),
		.io_space_out(slot_io[0]),
		.wait_out(slot_wait[2:0])
	);

	ecs_sel_slot #(
		.UBR_RESET(`ECS_UBRX_RESET)
	) slot1_u (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.cfg_load_in(cfg_load_in),
		.ctl_in(select_control_reg_1_in),
		.lbr_in(lower_bound_reg_1_in),
		.ubr_in(upper_bound_reg_1_in),
		.mem_byte_in(mem_byte),
		.io_byte_in(io_byte),
		.mem_access_in(mem_access_in),
		.io_access_in(io_access_in),
		.periph_in(periph),
		.hit_out(hit[1]),
		.io_space_out(slot_io[1]),
		.wait_out(slot_wait[5:3])
	);

	ecs_sel_slot #(
		.UBR_RESET(`ECS_UBRX_RESET)
	) slot2_u (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.cfg_load_in(cfg_load_in),
		.ctl_in(select_control_reg_2_in),
		.lbr_in(lower_bound_reg_2_in),
		.ubr_in(upper_bound_reg_2_in),
		.mem_byte_in(mem_byte),
		.io_byte_in(io_byte),
		.mem_access_in(mem_access_in),
		.io_access_in(io_access_in),
		.periph_in(periph),
		.hit_out(hit[2]),
		.io_space_out(slot_io[2]),
		.wait_out(slot_wait[8:6])
	);

	ecs_sel_slot #(
		.UBR_RESET(`ECS_UBRX_RESET)
	) slot3_u (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.cfg_load_in(cfg_load_in),
		.ctl_in(select_control_reg_3_in),
		.lbr_in(lower_bound_reg_3_in),
		.ubr_in(upper_bound_reg_3_in),
		.mem_byte_in(mem_byte),
		.io_byte_in(io_byte),
		.mem_access_in(mem_access_in),
		.io_access_in(io_access_in),
		.periph_in(periph),
		.hit_out(hit[3]),
		.io_space_out(slot_io[3]),
		.wait_out(slot_wait[11:9])
	);

	// RULE9 lowest number wins
	always @* begin
		win = 4'h0;
		win_io = 1'b0;
		win_wait = 3'h0;
		if (hit[0]) begin
			win = 4'h1;
		end else if (hit[1]) begin
			win = 4'h2;
		end else if (hit[2]) begin
			win = 4'h4;
		end else if (hit[3]) begin
			win = 4'h8;
		end
		for (j = 0; j < 4; j = j + 1) begin
			if (win[j]) begin
				win_io = slot_io[j];
				win_wait = slot_wait[j * 3 +: 3];
			end
		end
		any_win = |win;
	end

	// RULE13 up to seven wait states
	// RULE15 wait count from control bits
	always @* begin
		wait_cnt_d = wait_cnt_q;
		if (any_win && !prev_access_q) begin
			wait_cnt_d = win_wait;
		end else if (wait_cnt_q != 3'h0) begin
			wait_cnt_d = wait_cnt_q - 3'h1;
		end
	end

	// RULE11 select plus request plus direction
	// RULE17 io request on io match
	// RULE18 lines high otherwise
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			select_line_0_n_out <= 1'b1;
			select_line_1_n_out <= 1'b1;
			select_line_2_n_out <= 1'b1;
			select_line_3_n_out <= 1'b1;
			memory_request_strobe_n_out <= 1'b1;
			io_request_strobe_n_out <= 1'b1;
			read_strobe_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
			core_wait_out <= 1'b0;
			wait_cnt_q <= 3'h0;
			prev_access_q <= 1'b0;
		end else begin
			select_line_0_n_out <= ~win[0];
			select_line_1_n_out <= ~win[1];
			select_line_2_n_out <= ~win[2];
			select_line_3_n_out <= ~win[3];
			memory_request_strobe_n_out <= ~(any_win && !win_io);
			io_request_strobe_n_out <= ~(any_win && win_io);
			read_strobe_n_out <= ~(any_win && !write_in);
			write_strobe_n_out <= ~(any_win && write_in);
			// stall is held while counting so the core sees whole cycles
			core_wait_out <= (wait_cnt_d != 3'h0);
			wait_cnt_q <= wait_cnt_d;
			prev_access_q <= access;
		end
	end
endmodule // ecs_decoder

// one select: its three configuration bytes and its own address match
module ecs_sel_slot #(
	parameter [7:0] UBR_RESET = `ECS_UBRX_RESET
) (
	input wire clock_in,
	input wire rst_n_in,
	input wire cfg_load_in,
	input wire [7:0] ctl_in,
	input wire [7:0] lbr_in,
	input wire [7:0] ubr_in,
	input wire [7:0] mem_byte_in,
	input wire [7:0] io_byte_in,
	input wire mem_access_in,
	input wire io_access_in,
	input wire periph_in,
	output wire hit_out,
	output wire io_space_out,
	output wire [2:0] wait_out
);
	reg [7:0] ctl_q;
	reg [7:0] lbr_q;
	reg [7:0] ubr_q;
	wire mem_hit;
	wire io_hit;

	// RULE3 memory space reset
	// RULE14 bound reset values
	// RULE5 three registers per select
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			ctl_q <= `ECS_CTL_RESET;
			lbr_q <= `ECS_LBR_RESET;
			ubr_q <= UBR_RESET;
		end else if (cfg_load_in) begin
			ctl_q <= ctl_in;
			lbr_q <= lbr_in;
			ubr_q <= ubr_in;
		end
	end

	// RULE6 range on top byte
	// RULE7 64 KB granularity
	// RULE8 equal bounds one page
	// RULE10 memory cycles only
	assign mem_hit = mem_access_in && (mem_byte_in >= lbr_q) && (mem_byte_in <= ubr_q);
	// RULE12 one 256-byte section
	// RULE16 high io byte equals lower bound
	// RULE17 peripheral window excluded
	assign io_hit = io_access_in && !periph_in && (io_byte_in == lbr_q);
	// RULE4 enable gate
	// RULE2 one space only
	assign hit_out = ctl_q[`ECS_CTL_EN_BIT] && (ctl_q[`ECS_CTL_IO_BIT] ? io_hit : mem_hit);
	assign io_space_out = ctl_q[`ECS_CTL_IO_BIT];
	assign wait_out = ctl_q[`ECS_CTL_WAIT_HI:`ECS_CTL_WAIT_LO];
endmodule // ecs_sel_slot

// *** ecs_dev_model.sv ***
// far-side model: one external chip hung on a select line
// assumes active-low select, request and read or write strobes
module ecs_dev_model (
	input wire sel_n_in,
	input wire req_n_in,
	input wire rd_n_in,
	input wire wr_n_in,
	output logic resp_out
);
	timeunit 1ns;
	timeprecision 1ns;
	assign resp_out = !sel_n_in && !req_n_in && (!rd_n_in || !wr_n_in);
endmodule // ecs_dev_model

// *** ecs_decoder_chk.sv ***
// checker: strobe and select relations at the decoder ports
// assumes a synchronous active-low reset on clock_in
module ecs_decoder_chk (
	input wire clock_in,
	input wire rst_n_in,
	input wire [23:0] addr_in,
	input wire mem_access_in,
	input wire io_access_in,
	input wire write_in,
	input wire select_line_0_n_out,
	input wire select_line_1_n_out,
	input wire select_line_2_n_out,
	input wire select_line_3_n_out,
	input wire memory_request_strobe_n_out,
	input wire io_request_strobe_n_out,
	input wire read_strobe_n_out,
	input wire write_strobe_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [3:0] sel = ~{select_line_3_n_out, select_line_2_n_out, select_line_1_n_out, select_line_0_n_out};
	wire mq = !memory_request_strobe_n_out;
	wire iq = !io_request_strobe_n_out;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	property p_one; $onehot0(sel); endproperty
	a_one: assert property (p_one) else $error("two selects low");
	property p_mem; mq |-> $past(mem_access_in); endproperty
	a_mem: assert property (p_mem) else $error("memory strobe without access");
	property p_io; iq |-> $past(io_access_in) && $past(addr_in[15:7]) != 9'h001; endproperty
	a_io: assert property (p_io) else $error("bad io strobe");
	property p_kind; !(mq && iq); endproperty
	a_kind: assert property (p_kind) else $error("both requests low");
	property p_rd; !read_strobe_n_out |-> !$past(write_in) && write_strobe_n_out; endproperty
	a_rd: assert property (p_rd) else $error("read strobe wrong");
	property p_wr; !write_strobe_n_out |-> $past(write_in); endproperty
	a_wr: assert property (p_wr) else $error("write strobe wrong");
	property p_req; (mq || iq) |-> |sel; endproperty
	a_req: assert property (p_req) else $error("request without select");
	property p_idle; !mem_access_in && !io_access_in |=> sel == 4'h0; endproperty
	a_idle: assert property (p_idle) else $error("select without access");
endmodule // ecs_decoder_chk
bind ecs_decoder ecs_decoder_chk chk_u (.*);

// *** external_chip_select_decoder_tb_top.sv ***
// bench: random configs and accesses against a behavioural decode model
// assumes one-cycle registered outputs and cfg_load used from the next cycle
module external_chip_select_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 0, rst_n_in = 0, mem_access_in = 0, io_access_in = 0, write_in = 0, cfg_load_in = 0;
	logic [23:0] addr_in = 0;
	logic [7:0] c[4] = '{default: 0}, l[4] = '{default: 0}, u[4] = '{default: 0};
	logic select_line_0_n_out, select_line_1_n_out, select_line_2_n_out, select_line_3_n_out, resp;
	logic memory_request_strobe_n_out, io_request_strobe_n_out, read_strobe_n_out, write_strobe_n_out, core_wait_out;
	logic [8:0] exp = 9'h0ff;
	logic expw = 0;
	int wk = -1, wcnt = 0, pacc = 0;
	int n_mismatch = 0, n_tests = 0, r, mc[4] = '{0, 0, 0, 0}, ml[4] = '{0, 0, 0, 0}, mu[4] = '{255, 0, 0, 0};
	always #20 clock_in = ~clock_in;
	ecs_decoder dut_u (.*, .select_control_reg_0_in(c[0]), .select_control_reg_1_in(c[1]),
		.select_control_reg_2_in(c[2]), .select_control_reg_3_in(c[3]), .lower_bound_reg_0_in(l[0]),
		.lower_bound_reg_1_in(l[1]), .lower_bound_reg_2_in(l[2]), .lower_bound_reg_3_in(l[3]),
		.upper_bound_reg_0_in(u[0]), .upper_bound_reg_1_in(u[1]), .upper_bound_reg_2_in(u[2]),
		.upper_bound_reg_3_in(u[3]));
	ecs_dev_model dev_u (.sel_n_in(select_line_0_n_out), .req_n_in(memory_request_strobe_n_out &
		io_request_strobe_n_out), .rd_n_in(read_strobe_n_out), .wr_n_in(write_strobe_n_out), .resp_out(resp));
	// few byte values so bounds, pages and priority collide often
	function automatic logic [7:0] pick();
		return {2'($urandom_range(3)), 6'h0};
	endfunction
	function automatic logic [8:0] model();
		logic [8:0] e = 9'h0ff;
		wk = -1;
		for (int k = 3; k >= 0; k--) begin
			if (mc[k][3] && (mc[k][4] ? io_access_in && addr_in[15:8] == ml[k] && addr_in[15:7] != 9'h001 :
				mem_access_in && addr_in[23:16] >= ml[k] && addr_in[23:16] <= mu[k])) begin
				e = {k == 0, write_in, !write_in, mc[k][4] == 1, mc[k][4] == 0, 4'hf & ~(4'h1 << k)};
				wk = k;
			end
		end
		return e;
	endfunction
	task automatic chk(logic [8:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t outputs %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_wait(logic got);
		n_tests++;
		if (got !== expw) begin
			n_mismatch++;
			$display("[ERR] %0t core wait %b expected %b", $time, got, expw);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#150000;
		n_mismatch++;
		conclude();
	end
	initial begin
		void'($urandom(32'h082e));
		repeat (10) @(negedge clock_in);
		rst_n_in = 1;
		repeat (3000) begin
			@(negedge clock_in);
			chk({resp, read_strobe_n_out, write_strobe_n_out, memory_request_strobe_n_out, io_request_strobe_n_out,
				select_line_3_n_out, select_line_2_n_out, select_line_1_n_out, select_line_0_n_out});
			chk_wait(core_wait_out);
			r = $urandom_range(2);
			mem_access_in = r == 1;
			io_access_in = r == 2;
			write_in = $urandom;
			addr_in = {pick(), pick(), 8'($urandom)};
			cfg_load_in = $urandom_range(7) == 0;
			foreach (c[k]) begin
				c[k] = $urandom;
				l[k] = pick();
				u[k] = pick();
			end
			exp = model();
			// wait loads only on an access after an idle cycle, then counts down
			wcnt = (wk >= 0 && pacc == 0) ? int'(mc[wk][7:5]) : (wcnt > 0 ? wcnt - 1 : 0);
			pacc = mem_access_in | io_access_in;
			expw = wcnt != 0;
			if (cfg_load_in)
				foreach (c[k]) begin
					mc[k] = c[k];
					ml[k] = l[k];
					mu[k] = u[k];
				end
		end
		conclude();
	end
endmodule // external_chip_select_decoder_tb_top
